// *** pkg/abfp_pkg.sv ***
// Package of constants and carrier types for the async byte FIFO port
package abfp_pkg;
    localparam int ABFP_DATA_W = 8;
    localparam int ABFP_RX_DEPTH = 16;
    localparam int ABFP_TX_DEPTH = 16;
    localparam int ABFP_PTR_W = 4;
    localparam int ABFP_SYNC_STAGES = 3;
    // Strobe level and data/count values after reset (strobes idle high)
    localparam logic ABFP_STROBE_IDLE = 1'b1;
    localparam logic [ABFP_DATA_W-1:0] ABFP_DATA_RESET = 8'h00;
    localparam logic [ABFP_PTR_W:0] ABFP_COUNT_RESET = 5'h00;

    typedef logic [ABFP_DATA_W-1:0] abfp_byte_t;

    // Byte stream toward or from the internal USB engine
    typedef struct packed {
        logic valid;
        abfp_byte_t data;
    } abfp_stream_s;

    // Pins facing the external bus master
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic flush_wakeup_n;
    } abfp_strobes_s;

    typedef enum logic [1:0] {
        ABFP_RD_IDLE,
        ABFP_RD_DRIVE,
        ABFP_RD_GAP
    } abfp_rd_state_e;
endpackage : abfp_pkg

// *** verilog/abfp_mem.sv ***
// Small byte buffer memory with registered read data
`timescale 1ns/1ps
module abfp_mem
    import abfp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [ABFP_PTR_W-1:0] wr_addr,
    input wire abfp_byte_t wr_data,
    input wire logic [ABFP_PTR_W-1:0] rd_addr,
    output abfp_byte_t rd_data
);
    abfp_byte_t mem_reg [0:(1<<ABFP_PTR_W)-1];

    // Write port and registered read, no reset so it maps onto RAM
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule : abfp_mem

// *** verilog/abfp_port.sv ***
// Asynchronous strobe-driven byte FIFO port, one channel
`timescale 1ns/1ps
module abfp_port
    import abfp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic fifo_mode_en,
    input wire logic remote_wakeup_en,
    input wire logic power_enable_n,
    input wire abfp_strobes_s strobes,
    input wire abfp_byte_t fifo_data_in,
    output abfp_byte_t fifo_data_out,
    output logic fifo_data_oe,
    output logic rx_available_n,
    output logic rx_available_oe,
    output logic tx_room_n,
    output logic tx_room_oe,
    input wire abfp_stream_s usb_rx,
    output logic usb_rx_ready,
    output abfp_stream_s usb_tx,
    input wire logic usb_tx_ready,
    output logic send_immediate,
    output logic resume_request
);
    localparam int DEPTH_MAX = 1 << ABFP_PTR_W;

    // Synchroniser chains, one per strobe; only the last stages are looked at
    logic [2:0] sync_in;
    logic [ABFP_SYNC_STAGES-1:0] sync_reg [0:2];
    logic [ABFP_SYNC_STAGES-1:0] sync_next [0:2];
    logic [2:0] synced;
    logic [2:0] prev_reg;
    logic [2:0] fell;
    logic [2:0] rose;

    assign sync_in = {strobes.flush_wakeup_n, strobes.wr_n, strobes.rd_n};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_comb begin
                sync_next[gi] = {sync_reg[gi][ABFP_SYNC_STAGES-2:0], sync_in[gi]};
            end
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    sync_reg[gi] <= {ABFP_SYNC_STAGES{ABFP_STROBE_IDLE}};
                end else begin
                    sync_reg[gi] <= sync_next[gi];
                end
            end
            assign synced[gi] = sync_reg[gi][ABFP_SYNC_STAGES-1];
            // Edges are taken only from the settled stage
            assign fell[gi] = prev_reg[gi] & ~synced[gi];
            assign rose[gi] = ~prev_reg[gi] & synced[gi];
        end
    endgenerate

    // Previous settled strobe levels for edge detection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_reg <= {3{ABFP_STROBE_IDLE}};
        end else begin
            prev_reg <= synced;
        end
    end

    // Receive buffer pointers and state
    logic [ABFP_PTR_W-1:0] rx_wptr_reg, rx_wptr_next, rx_rptr_reg, rx_rptr_next;
    logic [ABFP_PTR_W:0] rx_cnt_reg, rx_cnt_next;
    abfp_rd_state_e rd_state_reg, rd_state_next;
    abfp_byte_t rx_head;
    abfp_byte_t dout_reg, dout_next;
    logic rx_push, rx_pop;

    assign usb_rx_ready = fifo_mode_en && (rx_cnt_reg != DEPTH_MAX[ABFP_PTR_W:0]);
    assign rx_push = usb_rx.valid && usb_rx_ready;

    abfp_mem u_rx_mem (
        .ref_clk(ref_clk),
        .wr_en(rx_push),
        .wr_addr(rx_wptr_reg),
        .wr_data(usb_rx.data),
        .rd_addr(rx_rptr_next),
        .rd_data(rx_head)
    );

    // Read strobe sequencing: drive on fall, advance on rise, flag gap after rise
    always_comb begin
        rd_state_next = rd_state_reg;
        dout_next = dout_reg;
        rx_pop = 1'b0;
        case (rd_state_reg)
            ABFP_RD_IDLE: begin
                if (fell[0] && fifo_mode_en && rx_cnt_reg != '0) begin
                    dout_next = rx_head;
                    rd_state_next = ABFP_RD_DRIVE;
                end
            end
            ABFP_RD_DRIVE: begin
                if (rose[0]) begin
                    rx_pop = 1'b1;
                    rd_state_next = ABFP_RD_GAP;
                end
            end
            default: begin
                // One idle cycle keeps the flag high after every read
                rd_state_next = ABFP_RD_IDLE;
            end
        endcase
    end

    // Receive pointer and count updates
    always_comb begin
        rx_wptr_next = rx_push ? rx_wptr_reg + 1'b1 : rx_wptr_reg;
        rx_rptr_next = rx_pop ? rx_rptr_reg + 1'b1 : rx_rptr_reg;
        rx_cnt_next = rx_cnt_reg;
        if (rx_push && !rx_pop) begin
            rx_cnt_next = rx_cnt_reg + 1'b1;
        end else if (rx_pop && !rx_push) begin
            rx_cnt_next = rx_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_state_reg <= ABFP_RD_IDLE;
            dout_reg <= ABFP_DATA_RESET;
            rx_wptr_reg <= '0;
            rx_rptr_reg <= '0;
            rx_cnt_reg <= ABFP_COUNT_RESET;
        end else begin
            rd_state_reg <= rd_state_next;
            dout_reg <= dout_next;
            rx_wptr_reg <= rx_wptr_next;
            rx_rptr_reg <= rx_rptr_next;
            rx_cnt_reg <= rx_cnt_next;
        end
    end

    // Data lines driven only while the read strobe is low and a read is live
    assign fifo_data_out = dout_reg;
    assign fifo_data_oe = (rd_state_reg == ABFP_RD_DRIVE) && !synced[0];

    // Transmit buffer lives in its own memory, drained toward the USB engine
    logic [ABFP_PTR_W-1:0] tx_wptr_reg, tx_wptr_next, tx_rptr_reg, tx_rptr_next;
    logic [ABFP_PTR_W:0] tx_cnt_reg, tx_cnt_next;
    logic tx_push, tx_pop, tx_valid;
    logic tx_stale_reg, tx_stale_next;
    abfp_byte_t tx_head;

    assign tx_push = fell[1] && fifo_mode_en && tx_cnt_reg != DEPTH_MAX[ABFP_PTR_W:0];
    // Registered read lags a write into the head slot by one cycle, so valid waits for it
    assign tx_valid = (tx_cnt_reg != '0) && !tx_stale_reg;
    assign tx_pop = tx_valid && usb_tx_ready;
    assign usb_tx.valid = tx_valid;
    assign usb_tx.data = tx_head;

    // Captured byte is the one on the lines once the fall has passed the synchroniser
    abfp_mem u_tx_mem (
        .ref_clk(ref_clk),
        .wr_en(tx_push),
        .wr_addr(tx_wptr_reg),
        .wr_data(fifo_data_in),
        .rd_addr(tx_rptr_next),
        .rd_data(tx_head)
    );

    always_comb begin
        tx_stale_next = tx_push && (tx_wptr_reg == tx_rptr_next);
        tx_wptr_next = tx_push ? tx_wptr_reg + 1'b1 : tx_wptr_reg;
        tx_rptr_next = tx_pop ? tx_rptr_reg + 1'b1 : tx_rptr_reg;
        tx_cnt_next = tx_cnt_reg;
        if (tx_push && !tx_pop) begin
            tx_cnt_next = tx_cnt_reg + 1'b1;
        end else if (tx_pop && !tx_push) begin
            tx_cnt_next = tx_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_stale_reg <= 1'b0;
            tx_wptr_reg <= '0;
            tx_rptr_reg <= '0;
            tx_cnt_reg <= ABFP_COUNT_RESET;
        end else begin
            tx_stale_reg <= tx_stale_next;
            tx_wptr_reg <= tx_wptr_next;
            tx_rptr_reg <= tx_rptr_next;
            tx_cnt_reg <= tx_cnt_next;
        end
    end

    // Flags: open while reset is asserted or the mode is off, active low otherwise
    logic rx_flag_n_reg, rx_flag_n_next, tx_flag_n_reg, tx_flag_n_next;
    always_comb begin
        rx_flag_n_next = !(fifo_mode_en && rd_state_next == ABFP_RD_IDLE
                           && rd_state_reg == ABFP_RD_IDLE && rx_cnt_next != '0);
        tx_flag_n_next = !(fifo_mode_en && tx_cnt_next != DEPTH_MAX[ABFP_PTR_W:0]);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_flag_n_reg <= 1'b1;
            tx_flag_n_reg <= 1'b1;
        end else begin
            rx_flag_n_reg <= rx_flag_n_next;
            tx_flag_n_reg <= tx_flag_n_next;
        end
    end

    assign rx_available_n = rx_flag_n_reg;
    assign tx_room_n = tx_flag_n_reg;
    assign rx_available_oe = !rst && fifo_mode_en;
    assign tx_room_oe = !rst && fifo_mode_en;

    // Flush/wakeup pulse: resume when suspended with wakeup enabled, send-immediate when not suspended
    logic send_reg, send_next, resume_reg, resume_next;
    always_comb begin
        send_next = fell[2] && fifo_mode_en && !power_enable_n;
        resume_next = fell[2] && fifo_mode_en && power_enable_n && remote_wakeup_en;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            send_reg <= 1'b0;
            resume_reg <= 1'b0;
        end else begin
            send_reg <= send_next;
            resume_reg <= resume_next;
        end
    end

    assign send_immediate = send_reg;
    assign resume_request = resume_reg;
endmodule : abfp_port

// *** tb/abfp_port_monitor.sv ***
// Concurrent checks on the byte FIFO port pins
`timescale 1ns/1ps
module abfp_port_monitor
    import abfp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic fifo_mode_en,
    input wire logic remote_wakeup_en,
    input wire logic power_enable_n,
    input wire abfp_strobes_s strobes,
    input wire abfp_byte_t fifo_data_out,
    input wire logic fifo_data_oe,
    input wire logic rx_available_n,
    input wire logic rx_available_oe,
    input wire logic tx_room_n,
    input wire logic tx_room_oe,
    input wire abfp_stream_s usb_tx,
    input wire logic send_immediate,
    input wire logic resume_request
);
    default clocking @(posedge ref_clk); endclocking
    // Flag release is checked inside reset, so it carries no disable
    AST_FLAG_RELEASE: assert property (rst |-> !rx_available_oe && !tx_room_oe)
        else $error("flag driven during reset");
    AST_MODE_GATE: assert property (disable iff (rst) fifo_data_oe || rx_available_oe || tx_room_oe |-> fifo_mode_en)
        else $error("pins driven with mode off");
    AST_DRIVE_ON_READ: assert property (disable iff (rst) $rose(fifo_data_oe) |-> !strobes.rd_n)
        else $error("data driven without read strobe");
    AST_DATA_HELD: assert property (disable iff (rst) fifo_data_oe && $past(fifo_data_oe) |-> $stable(fifo_data_out))
        else $error("read byte changed while driven");
    // Strobe rise must keep the flag high while the pointer advances
    AST_RX_FLAG_UP: assert property (disable iff (rst) $rose(strobes.rd_n) |-> rx_available_n [*4])
        else $error("receive flag low too soon after read");
    AST_TX_CAPTURE: assert property (disable iff (rst) $fell(strobes.wr_n) && !tx_room_n |-> ##[3:5] usb_tx.valid)
        else $error("written byte not captured");
    AST_SEND_IMM: assert property (disable iff (rst)
        $fell(strobes.flush_wakeup_n) && !power_enable_n |-> ##[3:5] send_immediate)
        else $error("flush gave no send pulse");
    AST_RESUME: assert property (disable iff (rst)
        $fell(strobes.flush_wakeup_n) && power_enable_n && remote_wakeup_en |-> ##[3:5] resume_request)
        else $error("flush gave no resume pulse");
    AST_PULSE_SHORT: assert property (disable iff (rst)
        send_immediate || resume_request |=> !send_immediate && !resume_request)
        else $error("send pulse longer than one cycle");
    cover property (disable iff (rst) $rose(fifo_data_oe));
    cover property (disable iff (rst) $rose(usb_tx.valid));
    cover property (disable iff (rst) resume_request);
endmodule : abfp_port_monitor

// *** tb/abfp_master_model.sv ***
// External bus master driving the strobes and data lines
`timescale 1ns/1ps
module abfp_master_model
    import abfp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rx_available_n,
    input wire logic tx_room_n,
    input wire logic fifo_data_oe,
    input wire abfp_byte_t fifo_data_out,
    output abfp_strobes_s strobes,
    output abfp_byte_t bus_data
);
    initial begin
        strobes = '1;
        bus_data = 8'h5A;
    end
    // Read holds the strobe until the port drives, slow adds extra low time
    task automatic rd(output abfp_byte_t b, input int slow);
        int n;
        n = 0;
        while (rx_available_n && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        strobes.rd_n = 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (!fifo_data_oe && n < 20);
        repeat (slow + 1) @(negedge ref_clk);
        b = fifo_data_out;
        strobes.rd_n = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask : rd
    // Data is held long enough to cover the synchroniser delay
    task automatic wr(input abfp_byte_t b);
        int n;
        n = 0;
        while (tx_room_n && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        bus_data = b;
        strobes.wr_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        strobes.wr_n = 1'b1;
        bus_data = ~b; // Released bus shows no stale byte
        repeat (5) @(negedge ref_clk);
    endtask : wr
    task automatic flush();
        strobes.flush_wakeup_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        strobes.flush_wakeup_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        strobes.flush_wakeup_n = 1'b1;
    endtask : flush
endmodule : abfp_master_model

// *** tb/async_byte_fifo_port_tb.sv ***
// Self-checking testbench for the byte FIFO port
`timescale 1ns/1ps
module async_byte_fifo_port_tb;
    import abfp_pkg::*;
    logic ref_clk, rst, fifo_mode_en, remote_wakeup_en, power_enable_n, usb_tx_ready;
    logic fifo_data_oe, rx_available_n, rx_available_oe, tx_room_n, tx_room_oe;
    logic usb_rx_ready, send_immediate, resume_request, rx_pin, tx_pin;
    abfp_strobes_s strobes;
    abfp_byte_t fifo_data_out, m_data, data_pin;
    abfp_byte_t n_send = 8'h00, n_wake = 8'h00;
    abfp_stream_s usb_rx, usb_tx;
    int errors = 0, cmp_count = 0, cycles = 0;
    // Pins resolve through the device enables and the flag pull-ups
    assign data_pin = fifo_data_oe ? fifo_data_out : m_data;
    assign rx_pin = rx_available_oe ? rx_available_n : 1'b1;
    assign tx_pin = tx_room_oe ? tx_room_n : 1'b1;
    abfp_port i_dut (.ref_clk, .rst, .fifo_mode_en, .remote_wakeup_en, .power_enable_n, .strobes,
        .fifo_data_in(data_pin), .fifo_data_out, .fifo_data_oe, .rx_available_n, .rx_available_oe, .tx_room_n,
        .tx_room_oe, .usb_rx, .usb_rx_ready, .usb_tx, .usb_tx_ready, .send_immediate, .resume_request);
    abfp_master_model i_master (.ref_clk, .rx_available_n(rx_pin), .tx_room_n(tx_pin), .fifo_data_oe,
        .fifo_data_out, .strobes, .bus_data(m_data));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Expected {send, wake} pulses from one flush at the given levels
    function automatic logic [1:0] flush_expect(input logic pe_n, input logic wake_en);
        return {!pe_n, pe_n && wake_en};
    endfunction : flush_expect
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // Pulse counters and the hang limit
    always @(posedge ref_clk) begin
        n_send <= n_send + 8'(send_immediate === 1'b1);
        n_wake <= n_wake + 8'(resume_request === 1'b1);
        cycles++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        abfp_byte_t b;
        abfp_byte_t q[$];
        logic [7:0] es, ew;
        logic [1:0] fx;
        {rst, fifo_mode_en, power_enable_n, usb_tx_ready} = 4'hF;
        {remote_wakeup_en, usb_rx, es, ew, fx} = '0;
        void'($urandom(32'h3645));
        repeat (4) @(negedge ref_clk);
        chk("flag_oe", {rx_available_oe, tx_room_oe}, 8'h00);
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            b = (i == 0) ? 8'hFF : 8'($urandom);
            q.push_back(b);
            usb_rx = {1'b1, b};
            @(negedge ref_clk);
        end
        usb_rx = '0;
        repeat (6) @(negedge ref_clk);
        chk("rx_flag", rx_pin, 8'h00);
        for (int i = 0; i < 5; i++) begin
            i_master.rd(b, (i % 2) * 4);
            chk("rx_byte", b, q.pop_front());
        end
        chk("rx_empty", rx_pin, 8'h01);
        $display("read test done");
        usb_tx_ready = 1'b0;
        for (int i = 0; i < ABFP_TX_DEPTH; i++) begin
            b = (i == 0) ? 8'h00 : 8'($urandom);
            q.push_back(b);
            i_master.wr(b);
        end
        chk("tx_full", tx_pin, 8'h01);
        usb_tx_ready = 1'b1;
        repeat (40) begin
            if (usb_tx.valid === 1'b1 && q.size() > 0) chk("tx_byte", usb_tx.data, q.pop_front());
            @(negedge ref_clk);
        end
        chk("tx_left", 8'(q.size()), 8'h00);
        $display("write test done");
        for (int i = 0; i < 3; i++) begin
            // Normal, suspended without wakeup, suspended with wakeup
            {power_enable_n, remote_wakeup_en} = 2'(i + 1);
            fx = flush_expect(power_enable_n, remote_wakeup_en);
            es = es + 8'(fx[1]);
            ew = ew + 8'(fx[0]);
            i_master.flush();
            repeat (8) @(negedge ref_clk);
            chk("send_cnt", n_send, es);
            chk("wake_cnt", n_wake, ew);
        end
        $display("flush test done");
        fifo_mode_en = 1'b0;
        @(negedge ref_clk);
        chk("mode_off_oe", {fifo_data_oe, rx_available_oe, tx_room_oe, usb_rx_ready}, 8'h00);
        $display("mode test done");
        tally_and_finish();
    end
endmodule : async_byte_fifo_port_tb
bind abfp_port abfp_port_monitor i_mon (.ref_clk, .rst, .fifo_mode_en, .remote_wakeup_en, .power_enable_n,
    .strobes, .fifo_data_out, .fifo_data_oe, .rx_available_n, .rx_available_oe, .tx_room_n, .tx_room_oe,
    .usb_tx, .send_immediate, .resume_request);
